// file: include/hti_pkg.sv
// Purpose: Shared constants and types of the haptic two-wire target port
// Assumes: One system clock; the bus lines are sampled, never used as clocks
// Notes: Bus addresses are 7-bit values without the direction bit

package hti_pkg;

   // Target addresses on the two-wire bus
   localparam logic [6:0] HTI_ADDR_OWN = 7'h5a;
   localparam logic [6:0] HTI_ADDR_BCAST = 7'h58;

   // Register holding the process trigger bit, and its position
   localparam logic [7:0] HTI_GO_INDEX = 8'h0c;
   localparam int unsigned HTI_GO_BIT = 0;

   // Byte and bit counts of the serial framing
   localparam logic [3:0] HTI_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] HTI_LAST_SEND_BIT = 4'h7;

   // Reset values of the port's own state
   localparam logic [7:0] HTI_PTR_RESET = 8'h00;
   localparam logic [7:0] HTI_SHIFT_RESET = 8'h00;

   // Protocol engine states
   typedef enum logic [4:0]
   {
      HTI_ST_IDLE = 5'b00001,
      HTI_ST_RECV = 5'b00010,
      HTI_ST_ACK = 5'b00100,
      HTI_ST_LOAD = 5'b01000,
      HTI_ST_SEND = 5'b10000
   } hti_state_e;

   // Meaning of the byte being received
   typedef enum logic [2:0]
   {
      HTI_KIND_ADDR = 3'b001,
      HTI_KIND_INDEX = 3'b010,
      HTI_KIND_DATA = 3'b100
   } hti_kind_e;

endpackage : hti_pkg

// file: include/hti_line_if.sv
// Purpose: Carries conditioned bus line events to the protocol engine
// Assumes: All signals are one-cycle pulses except sda_lvl
// Notes: Produced by the line conditioner, read by the target engine

`timescale 1ns/1ns
`default_nettype none

interface hti_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic start_det;
   logic stop_det;

   // Conditioner side
   modport cond
   (
      output scl_rise,
      output scl_fall,
      output sda_lvl,
      output start_det,
      output stop_det
   );

   // Engine side
   modport eng
   (
      input scl_rise,
      input scl_fall,
      input sda_lvl,
      input start_det,
      input stop_det
   );
endinterface : hti_line_if

`default_nettype wire

// file: rtl/hti_line_cond.sv
// Purpose: Synchronises SCL and SDA and detects edges, start and stop
// Assumes: Bus lines are asynchronous to clk and far slower than it
// Notes: First synchroniser stage feeds only the second stage

`timescale 1ns/1ns
`default_nettype none

module hti_line_cond
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Raw bus line levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Conditioned events
   hti_line_if.cond line
);
   import hti_pkg::*;

   logic [1:0] scl_meta_q, scl_meta_d;
   logic [1:0] sda_meta_q, sda_meta_d;
   logic scl_prev_q, scl_prev_d;
   logic sda_prev_q, sda_prev_d;
   logic rise_q, rise_d, fall_q, fall_d;
   logic start_q, start_d, stop_q, stop_d;
   logic lvl_q, lvl_d;

   // Next values; the prev stage reads only the second synchroniser flop
   always_comb
   begin
      scl_meta_d = {scl_meta_q[0], scl_i};
      sda_meta_d = {sda_meta_q[0], sda_i};
      scl_prev_d = scl_meta_q[1];
      sda_prev_d = sda_meta_q[1];
      rise_d = scl_meta_q[1] & ~scl_prev_q;
      fall_d = ~scl_meta_q[1] & scl_prev_q;
      // SDA edges while SCL stays high are bus conditions [RQ7]
      start_d = scl_meta_q[1] & scl_prev_q & sda_prev_q & ~sda_meta_q[1]; // [RQ7]
      stop_d = scl_meta_q[1] & scl_prev_q & ~sda_prev_q & sda_meta_q[1]; // [RQ7]
      lvl_d = sda_meta_q[1];
   end

   // Registers; idle bus reads high, so reset to released lines
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_meta_q <= 2'h3;
         sda_meta_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         start_q <= 1'b0;
         stop_q <= 1'b0;
         lvl_q <= 1'b1;
      end
      else if (clk_en)
      begin
         scl_meta_q <= scl_meta_d;
         sda_meta_q <= sda_meta_d;
         scl_prev_q <= scl_prev_d;
         sda_prev_q <= sda_prev_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         start_q <= start_d;
         stop_q <= stop_d;
         lvl_q <= lvl_d;
      end
   end

   assign line.scl_rise = rise_q;
   assign line.scl_fall = fall_q;
   assign line.sda_lvl = lvl_q;
   assign line.start_det = start_q;
   assign line.stop_det = stop_q;

endmodule : hti_line_cond

`default_nettype wire

// file: rtl/hti_target.sv
// Purpose: Two-wire bus target port of a haptic driver register space
// Assumes: clk much faster than SCL; register space sits on the user side
// Notes: Read data is taken in the same cycle as the read strobe
//
// Operation
// RQ1: Also acknowledge broadcast address when enabled
// RQ2: Broadcast write of trigger bit starts process
// RQ3: Accept accesses in standby and active alike
// RQ4: Bytes are eight bits, MSB first
// RQ5: Receiver acknowledges in ninth clock
// RQ6: Controller opens with start, closes with stop
// RQ7: SDA fall/rise with SCL high: start/stop
// RQ8: Data SDA changes only while SCL low
// RQ9: Controller sends address plus direction first
// RQ10: Acknowledge holds SDA low whole clock
// RQ11: No limit on bytes per transaction
// RQ12: Controller issues stop after last byte
// RQ13: Lines only pulled low or released
// RQ14: Respond to own fixed target address
// RQ15: First write byte is index, then autoincrement
// RQ16: Read uses index write then repeated start
// RQ17: Controller NACKs last read byte, then stops
// RQ18: Unmatched address gets no acknowledge
// RQ19: Start or stop mid-byte abandons byte

`timescale 1ns/1ns
`default_nettype none

module hti_target
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Bus lines, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Configuration
   input wire logic broadcast_address_enable,
   // Register space access
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Status and trigger
   output logic process_start,
   output logic bus_busy
);
   import hti_pkg::*;

   hti_line_if line ();

   hti_state_e state_q, state_d;
   hti_kind_e kind_q, kind_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic read_q, read_d;
   logic sda_o_q, scl_o_q, scl_oe_n_q;
   logic oe_n_q, oe_n_d;
   logic [7:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wr_q, wr_d;
   logic rd_q, rd_d;
   logic go_q, go_d;
   logic busy_q, busy_d;
   logic own_hit, bc_hit;

   // Line synchronisers and condition detectors
   hti_line_cond u_cond
   (
      .clk(clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .line(line)
   );

   // Address match against the received first byte
   assign own_hit = (shift_q[7:1] == HTI_ADDR_OWN); // [RQ14]
   assign bc_hit = broadcast_address_enable && (shift_q[7:1] == HTI_ADDR_BCAST); // [RQ1]

   // Protocol engine next state; no power-state gating, so standby and
   // active behave alike [RQ3]
   always_comb
   begin
      state_d = state_q;
      kind_d = kind_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      read_d = read_q;
      oe_n_d = oe_n_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      go_d = 1'b0;
      busy_d = busy_q;
      if (line.start_det)
      begin
         // Any start, repeated or not, abandons the byte in flight [RQ19]
         state_d = HTI_ST_RECV;
         kind_d = HTI_KIND_ADDR;
         cnt_d = 4'h0;
         oe_n_d = 1'b1;
         busy_d = 1'b1;
      end
      else if (line.stop_det)
      begin
         state_d = HTI_ST_IDLE; // [RQ19]
         oe_n_d = 1'b1;
         busy_d = 1'b0;
      end
      else
      begin
         unique case (state_q)
            HTI_ST_IDLE:
            begin
               oe_n_d = 1'b1;
            end
            HTI_ST_RECV:
            begin
               if (line.scl_rise && cnt_q != HTI_BITS_PER_BYTE)
               begin
                  // Sample on rising SCL, MSB arrives first [RQ4]
                  shift_d = {shift_q[6:0], line.sda_lvl}; // [RQ4]
                  cnt_d = cnt_q + 4'h1;
               end
               else if (line.scl_fall && cnt_q == HTI_BITS_PER_BYTE)
               begin
                  // Byte complete; decide the acknowledge at SCL low [RQ5]
                  state_d = HTI_ST_ACK;
                  oe_n_d = 1'b0; // [RQ5] [RQ10]
                  unique case (kind_q)
                     HTI_KIND_ADDR:
                     begin
                        if (own_hit || bc_hit)
                        begin
                           read_d = shift_q[0];
                        end
                        else
                        begin
                           // Not ours: leave SDA released and wait [RQ18]
                           state_d = HTI_ST_IDLE; // [RQ18]
                           oe_n_d = 1'b1; // [RQ18]
                        end
                     end
                     HTI_KIND_INDEX:
                     begin
                        ptr_d = shift_q; // [RQ15]
                     end
                     default:
                     begin
                        // Data byte goes to the pointed register [RQ15]
                        addr_d = ptr_q;
                        wdata_d = shift_q;
                        wr_d = 1'b1;
                        ptr_d = ptr_q + 8'h01; // [RQ15] [RQ11]
                        // Trigger bit fires alike for own and broadcast address
                        go_d = (ptr_q == HTI_GO_INDEX) && shift_q[HTI_GO_BIT]; // [RQ2]
                     end
                  endcase
               end
            end
            HTI_ST_ACK:
            begin
               // After a received byte, hold SDA low until SCL falls after the ninth clock [RQ10]
               if (line.scl_fall)
               begin
                  oe_n_d = 1'b1;
                  cnt_d = 4'h0;
                  if (kind_q == HTI_KIND_ADDR && read_q)
                  begin
                     addr_d = ptr_q;
                     rd_d = 1'b1;
                     state_d = HTI_ST_LOAD;
                  end
                  else
                  begin
                     state_d = HTI_ST_RECV;
                     kind_d = (kind_q == HTI_KIND_ADDR) ? HTI_KIND_INDEX : HTI_KIND_DATA;
                  end
               end
            end
            HTI_ST_LOAD:
            begin
               // SCL is low here, so putting the MSB out is legal [RQ8]
               shift_d = reg_rdata;
               oe_n_d = reg_rdata[7]; // [RQ4] [RQ8] [RQ13]
               ptr_d = ptr_q + 8'h01; // [RQ11]
               cnt_d = 4'h0;
               state_d = HTI_ST_SEND;
            end
            HTI_ST_SEND:
            begin
               if (line.scl_fall && cnt_q != HTI_BITS_PER_BYTE)
               begin
                  // Next bit on falling SCL only [RQ8]
                  shift_d = {shift_q[6:0], 1'b0};
                  cnt_d = cnt_q + 4'h1;
                  // After the eighth bit release SDA for the controller's answer
                  oe_n_d = (cnt_q == HTI_LAST_SEND_BIT) ? 1'b1 : shift_q[6]; // [RQ5] [RQ8]
               end
               else if (line.scl_rise && cnt_q == HTI_BITS_PER_BYTE)
               begin
                  if (line.sda_lvl)
                  begin
                     // Not acknowledged: last byte, wait for stop [RQ17]
                     state_d = HTI_ST_IDLE; // [RQ17]
                  end
                  else
                  begin
                     cnt_d = 4'h0;
                     state_d = HTI_ST_ACK;
                     kind_d = HTI_KIND_ADDR;
                  end
               end
            end
            default:
            begin
               state_d = HTI_ST_IDLE;
               oe_n_d = 1'b1;
            end
         endcase
      end
   end

   // Engine registers; reset leaves the bus released
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= HTI_ST_IDLE;
         kind_q <= HTI_KIND_ADDR;
         cnt_q <= 4'h0;
         shift_q <= HTI_SHIFT_RESET;
         ptr_q <= HTI_PTR_RESET;
         read_q <= 1'b0;
         oe_n_q <= 1'b1;
         addr_q <= HTI_PTR_RESET;
         wdata_q <= HTI_SHIFT_RESET;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         go_q <= 1'b0;
         busy_q <= 1'b0;
         // Pin levels stay low and SCL is never pulled, so no high is driven
         sda_o_q <= 1'b0; // [RQ13]
         scl_o_q <= 1'b0;
         scl_oe_n_q <= 1'b1;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         kind_q <= kind_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         read_q <= read_d;
         oe_n_q <= oe_n_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         go_q <= go_d;
         busy_q <= busy_d;
         sda_o_q <= 1'b0; // [RQ13]
         scl_o_q <= 1'b0;
         scl_oe_n_q <= 1'b1;
      end
   end

   // Ports straight from flops; of the bus pins only the SDA enable ever moves [RQ13]
   assign sda_o = sda_o_q;
   assign sda_oe_n = oe_n_q;
   assign scl_o = scl_o_q;
   assign scl_oe_n = scl_oe_n_q;
   assign reg_addr = addr_q;
   assign reg_wdata = wdata_q;
   assign reg_wr = wr_q;
   assign reg_rd = rd_q;
   assign process_start = go_q; // [RQ2]
   assign bus_busy = busy_q;

endmodule : hti_target

`default_nettype wire

// file: tb/hti_target_props.sv
// Purpose: Concurrent checks on the ports of the two-wire target port
// Assumes: Bus pins settle slower than clk; clk_en held high in the bench
// Notes: Pin events reach the engine about three clocks late

`timescale 1ns/1ns
`default_nettype none

module hti_target_props
   import hti_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Bus lines
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_n,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   // Configuration and register side
   input wire logic broadcast_address_enable,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic process_start,
   input wire logic bus_busy
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Pin-level start and stop, before synchronisation
   sequence start_seq;
      scl_i && $fell(sda_i);
   endsequence
   sequence stop_seq;
      scl_i && $rose(sda_i);
   endsequence
   // Target holding SDA low as SCL goes high
   sequence pull_seq;
      $rose(scl_i) && !sda_oe_n;
   endsequence

   // Lines are only ever pulled low, never driven high
   scl_idle_a: assert property (scl_oe_n && !scl_o) else $error("SCL driven");
   sda_low_a: assert property (!sda_o) else $error("SDA driven high");
   // Strobes are single cycles and never overlap
   wr_pulse_a: assert property (reg_wr |=> !reg_wr) else $error("Write strobe long");
   rd_pulse_a: assert property (reg_rd |=> !reg_rd && !reg_wr) else $error("Read strobe long");
   // Trigger pulse tied to a write of the trigger bit
   go_cause_a: assert property (process_start |-> reg_wr && reg_addr == HTI_GO_INDEX
      && reg_wdata[HTI_GO_BIT]) else $error("Stray trigger");
   go_when_a: assert property (reg_wr && reg_addr == HTI_GO_INDEX && reg_wdata[HTI_GO_BIT]
      |-> process_start) else $error("Trigger missed");
   // Target moves SDA only well inside the SCL low phase
   sda_change_a: assert property ($changed(sda_oe_n) |-> !scl_i && !$past(scl_i, 3))
      else $error("SDA moved with SCL high");
   ack_hold_a: assert property (pull_seq |-> !sda_oe_n [*8])
      else $error("SDA released early");
   busy_start_a: assert property (start_seq |-> ##[1:8] bus_busy)
      else $error("Start not seen");
   busy_stop_a: assert property (stop_seq |-> ##[1:8] !bus_busy)
      else $error("Stop not seen");
endmodule : hti_target_props

bind hti_target hti_target_props hti_target_props_inst
(
   .clk(clk),
   .resetn(resetn),
   .clk_en(clk_en),
   .scl_i(scl_i),
   .scl_o(scl_o),
   .scl_oe_n(scl_oe_n),
   .sda_i(sda_i),
   .sda_o(sda_o),
   .sda_oe_n(sda_oe_n),
   .broadcast_address_enable(broadcast_address_enable),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .process_start(process_start),
   .bus_busy(bus_busy)
);

`default_nettype wire

// file: tb/hti_host_model.sv
// Purpose: Bus controller model for the two-wire target port
// Assumes: Both lines pulled up; a set pull bit drives the line low
// Notes: Quarter bit time Q clk keeps setup and hold above 6 clk

`timescale 1ns/1ns
`default_nettype none

module hti_host_model
#(
   parameter int Q = 8
)
(
   // Clock
   input wire logic clk,
   // Bus
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull
);
   // Lines released at time zero
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // Steps just after a clock edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : hold

   // Start or repeated start: SDA falls with SCL high
   task automatic start();
      sda_pull = 1'b0;
      hold(Q);
      scl_pull = 1'b0;
      hold(Q);
      sda_pull = 1'b1;
      hold(Q);
      scl_pull = 1'b1;
   endtask : start

   // Stop: SDA rises with SCL high, bus freed
   task automatic stop();
      hold(Q);
      sda_pull = 1'b1;
      hold(Q);
      scl_pull = 1'b0;
      hold(Q);
      sda_pull = 1'b0;
      hold(Q);
   endtask : stop

   // Data moves in SCL low only; lines pulled or released
   task automatic bit_x(input logic b, output logic r);
      hold(Q);
      sda_pull = ~b;
      hold(Q);
      scl_pull = 1'b0;
      hold(2 * Q);
      r = sda;
      scl_pull = 1'b1;
   endtask : bit_x

   // Eight bits MSB first, then the ninth clock for the ack
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask : send

   // Last byte of a read is answered with no ack
   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(~ack, r);
   endtask : recv
endmodule : hti_host_model

`default_nettype wire

// file: tb/hti_target_bench.sv
// Purpose: Self-checking bench of the two-wire target port
// Assumes: Register space modelled as index xor a5
// Notes: Expected writes queue up; a monitor checks each strobe

`timescale 1ns/1ns
`default_nettype none

module hti_target_bench;
   import hti_pkg::*;
   logic clk, resetn, bcast_en, scl_pull, sda_pull, scl, sda;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, reg_wr, reg_rd, process_start, bus_busy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [16:0] wq[$];
   logic [16:0] exp_w;
   logic [31:0] seed = 32'h8fa7;
   logic ack;
   logic r;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;

   // Wired-AND of both parties with pull-ups
   assign scl = ~scl_pull & (scl_oe_n | scl_o);
   assign sda = ~sda_pull & (sda_oe_n | sda_o);
   // Read data stands only while the read strobe does, so a late load shows
   assign reg_rdata = reg_rd ? (reg_addr ^ 8'ha5) : 8'h00;

   hti_host_model host (.clk(clk), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

   hti_target hti_target_inst
   (
      .clk(clk), .resetn(resetn), .clk_en(1'b1),
      .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .broadcast_address_enable(bcast_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .process_start(process_start), .bus_busy(bus_busy)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   // Write of n bytes from idx; bit 0 alternates so the trigger is seen set and clear
   task automatic wr(input logic [6:0] a, input logic [7:0] idx, input int n, input logic ea);
      logic [7:0] d;
      host.start();
      host.send({a, 1'b0}, ack);
      chk_bit(ack, ea);
      if (ea)
      begin
         host.send(idx, ack);
         for (int i = 0; i < n; i++)
         begin
            seed = lfsr(seed);
            d = {seed[7:1], i[0]};
            wq.push_back({(idx + i[7:0]) == HTI_GO_INDEX && d[HTI_GO_BIT], idx + i[7:0], d});
            host.send(d, ack);
            chk_bit(ack, 1'b1);
         end
      end
      host.stop();
   endtask : wr

   // Index write, repeated start, then n bytes read back
   task automatic rd(input logic [6:0] a, input logic [7:0] idx, input int n);
      logic [7:0] d;
      host.start();
      host.send({HTI_ADDR_OWN, 1'b0}, ack);
      host.send(idx, ack);
      host.start();
      host.send({a, 1'b1}, ack);
      chk_bit(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         host.recv(i < n - 1, d);
         chk_byte(d, (idx + i[7:0]) ^ 8'ha5);
      end
      host.stop();
   endtask : rd

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Each strobe takes the oldest expected write; looked at mid-cycle, where settled
   always @(negedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         $display("[FAIL] %0t run timed out", $time);
         complete_run();
      end
      else if (reg_wr === 1'b1)
      begin
         exp_w = wq.size() > 0 ? wq.pop_front() : 17'h1ffff;
         chk_byte(reg_addr, exp_w[15:8]);
         chk_byte(reg_wdata, exp_w[7:0]);
         chk_bit(process_start, exp_w[16]);
      end
   end

   initial
   begin
      resetn = 1'b0;
      bcast_en = 1'b0;
      host.hold(16);
      resetn = 1'b1;
      host.hold(8);
      chk_bit(sda_oe_n & scl_oe_n & ~bus_busy, 1'b1);
      wr(HTI_ADDR_OWN, 8'hfe, 3, 1'b1);
      $display("own write with wrap done");
      wr(HTI_ADDR_BCAST, 8'h0b, 1, 1'b0);
      bcast_en = 1'b1;
      wr(HTI_ADDR_BCAST, 8'h0b, 3, 1'b1);
      wr(HTI_ADDR_OWN, HTI_GO_INDEX, 1, 1'b1);
      $display("broadcast and trigger done");
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         wr(seed[6:0] | 7'h20, 8'h00, 1, 1'b0);
      end
      $display("unmatched addresses done");
      rd(HTI_ADDR_OWN, 8'hfe, 3);
      rd(HTI_ADDR_BCAST, 8'h30, 2);
      $display("reads done");
      // A start, then a stop, cuts a data byte after five bits; neither may write
      for (int k = 0; k < 2; k++)
      begin
         host.start();
         host.send({HTI_ADDR_OWN, 1'b0}, ack);
         host.send(8'h40, ack);
         for (int i = 0; i < 5; i++)
            host.bit_x(1'b0, r);
         if (k == 0)
            wr(HTI_ADDR_OWN, 8'h20, 1, 1'b1);
         else
            host.stop();
      end
      host.hold(20);
      chk_bit(wq.size() == 0, 1'b1);
      chk_bit(bus_busy, 1'b0);
      $display("abandoned byte done");
      complete_run();
   end
endmodule : hti_target_bench

`default_nettype wire
